// >>> inc/pbs_pkg.sv
// Package for the processor bus slave data phase: constants and carriers.
// Assumes a single 25 MHz core clock shared by all users of these types.
package pbs_pkg;

	// Transfer size codes on the tsiz field (bit 3 is tsiz[0], bits 2:0 tsiz[1:3])
	localparam logic [2:0] TSIZ_DOUBLE = 3'h0;
	localparam logic [2:0] TSIZ_EXT16 = 3'h1;
	localparam logic [2:0] TSIZ_EXT24 = 3'h2;
	localparam logic [2:0] TSIZ_BURST = 3'h2;

	// Beat and byte counts
	localparam int unsigned LINE_WORDS = 4;
	localparam logic [2:0] BEATS_SINGLE = 3'h1;
	localparam logic [2:0] BEATS_EXT16 = 3'h2;
	localparam logic [2:0] BEATS_EXT24 = 3'h3;
	localparam logic [2:0] BEATS_BURST = 3'h4;
	localparam logic [5:0] BYTES_DOUBLE = 6'h08;
	localparam logic [5:0] BYTES_EXT16 = 6'h10;
	localparam logic [5:0] BYTES_EXT24 = 6'h18;
	localparam logic [5:0] BYTES_BURST = 6'h20;
	localparam logic [5:0] REG_MAX_BYTES = 6'h04;

	// Register offset handling for eight-byte reads
	localparam logic [11:0] REG_OFFSET_MASK = 12'hff8;
	localparam logic [11:0] REG_UPPER_STEP = 12'h004;

	// Discard timer: 2^15 clocks
	localparam int unsigned DISCARD_CYCLES = 32768;
	localparam int unsigned DISC_W = 16;

	// Reset values
	localparam logic [7:0] LANES_RESET = 8'h00;
	localparam logic [2:0] COUNT_RESET = 3'h0;

	typedef enum logic [2:0] {
		DR_IDLE,
		DR_FETCH,
		DR_HELD,
		DR_PRIME,
		DR_SEND
	} pbs_fsm_type;

	// Claimed read request from the address phase
	typedef struct packed {
		logic is_reg;
		logic tbst_n;
		logic [3:0] tsiz;
		logic [31:0] addr;
	} pbs_req_type;

	// Fetch toward the memory or register side
	typedef struct packed {
		logic valid;
		logic is_reg;
		logic [31:0] addr;
		logic [2:0] beats;
	} pbs_fetch_type;

	// Returned data beat from the memory or register side
	typedef struct packed {
		logic valid;
		logic last;
		logic error;
		logic [63:0] data;
	} pbs_fill_type;

	// Data termination strobes toward the bus, active high
	typedef struct packed {
		logic artry;
		logic ta;
		logic tea;
		logic dval;
	} pbs_term_type;

endpackage

// >>> logic/pbs_line_buffer.sv
// Read line buffer: small word memory with registered read data.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/1ps
module pbs_line_buffer #(
	parameter int unsigned WIDTH = 64,
	parameter int unsigned DEPTH = 4,
	parameter int unsigned AW = 2
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// Read port
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] rdata;
	} pbs_buf_state_type;

	pbs_buf_state_type s_reg;
	pbs_buf_state_type s_next;

	always_comb begin
		s_next = s_reg;
		if (wr_en) begin
			s_next.mem[wr_addr] = wr_data;
		end
		s_next.rdata = s_reg.mem[rd_addr];
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rd_data = s_reg.rdata;

endmodule

// >>> logic/pbs_data_phase.sv
// Data phase of the processor bus slave: size decode, lanes, delayed reads.
// Assumes the address phase claims reads and hands them over on req_valid,
// and a memory or register side that answers a fetch with data beats.
`timescale 1ns/1ps
module pbs_data_phase #(
	parameter int unsigned DISCARD_LIMIT = pbs_pkg::DISCARD_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control bits
	input wire logic transfer_error_enable,
	input wire logic address_retry_enable,
	input wire logic upper_word_select,
	// Read request from the address phase
	input wire logic req_valid,
	input wire pbs_pkg::pbs_req_type req,
	output logic req_ready,
	// Data tenure toward the bus
	output pbs_pkg::pbs_term_type term,
	output logic [63:0] data_out,
	output logic data_valid,
	output logic [7:0] lane_enable,
	// Memory or register side
	output pbs_pkg::pbs_fetch_type fetch,
	input wire pbs_pkg::pbs_fill_type fill
);

	typedef struct packed {
		pbs_pkg::pbs_fsm_type fsm;
		pbs_pkg::pbs_req_type req;
		logic retry_mode;
		logic err;
		logic burst;
		logic ext;
		logic [2:0] beats;
		logic [2:0] cnt;
		logic [2:0] fill_cnt;
		logic [7:0] lanes;
		logic [pbs_pkg::DISC_W-1:0] disc;
		pbs_pkg::pbs_term_type term;
		pbs_pkg::pbs_fetch_type fetch;
	} pbs_state_type;

	pbs_state_type s_reg;
	pbs_state_type s_next;

	logic [5:0] req_bytes;
	logic [2:0] req_beats;
	logic req_burst;
	logic req_ext;
	logic [7:0] req_lanes;
	logic [11:0] reg_offset;
	logic reg_err;
	logic match;
	logic send_last;
	logic wr_en;
	logic [63:0] wr_data;
	logic [1:0] rd_addr;
	logic [63:0] rd_data;

	// Size decode
	always_comb begin
		req_burst = 1'b0;
		req_ext = 1'b0;
		req_beats = pbs_pkg::BEATS_SINGLE;
		req_bytes = {3'h0, req.tsiz[2:0]};
		if (!req.tbst_n) begin
			req_burst = 1'b1;
			req_beats = pbs_pkg::BEATS_BURST;
			req_bytes = pbs_pkg::BYTES_BURST;
		end else if (req.tsiz[3]) begin
			req_ext = 1'b1;
			if (req.tsiz[2:0] == pbs_pkg::TSIZ_EXT16) begin
				req_beats = pbs_pkg::BEATS_EXT16;
				req_bytes = pbs_pkg::BYTES_EXT16;
			end else begin
				req_beats = pbs_pkg::BEATS_EXT24;
				req_bytes = pbs_pkg::BYTES_EXT24;
			end
		end else if (req.tsiz[2:0] == pbs_pkg::TSIZ_DOUBLE) begin
			req_bytes = pbs_pkg::BYTES_DOUBLE;
		end
	end

	// Lanes: contiguous run from the low address bits, no swapping
	always_comb begin
		req_lanes = 8'hff;
		if (req_beats == pbs_pkg::BEATS_SINGLE && req_bytes != pbs_pkg::BYTES_DOUBLE) begin
			req_lanes = 8'((9'h001 << req_bytes[3:0]) - 9'h001) << req.addr[2:0];
		end
	end

	// Register access checks and eight-byte offset
	always_comb begin
		reg_offset = req.addr[11:0];
		reg_err = 1'b0;
		if (req.is_reg && req_bytes > pbs_pkg::REG_MAX_BYTES) begin
			if (transfer_error_enable || req_bytes > pbs_pkg::BYTES_DOUBLE) begin
				reg_err = 1'b1;
			end else begin
				reg_offset = req.addr[11:0] & pbs_pkg::REG_OFFSET_MASK;
				if (upper_word_select) begin
					reg_offset = reg_offset + pbs_pkg::REG_UPPER_STEP;
				end
			end
		end
	end

	assign match = (req == s_reg.req);
	assign send_last = (s_reg.cnt + 3'h1 == s_reg.beats);
	assign wr_en = (s_reg.fsm == pbs_pkg::DR_FETCH) && fill.valid;
	assign wr_data = s_reg.req.is_reg ? {fill.data[31:0], fill.data[31:0]} : fill.data;
	assign rd_addr = (s_reg.fsm == pbs_pkg::DR_SEND) ? 2'(s_reg.cnt + 3'h1) : 2'h0;

	always_comb begin
		s_next = s_reg;
		s_next.term = '0;
		s_next.fetch.valid = 1'b0;
		case (s_reg.fsm)
			pbs_pkg::DR_IDLE: begin
				if (req_valid) begin
					if (reg_err) begin
						s_next.term.tea = transfer_error_enable;
						s_next.term.ta = !transfer_error_enable;
					end else begin
						s_next.req = req;
						s_next.retry_mode = address_retry_enable;
						s_next.term.artry = address_retry_enable;
						s_next.burst = req_burst;
						s_next.ext = req_ext;
						s_next.beats = req_beats;
						s_next.lanes = req_lanes;
						s_next.fill_cnt = pbs_pkg::COUNT_RESET;
						s_next.err = 1'b0;
						s_next.fetch.valid = 1'b1;
						s_next.fetch.is_reg = req.is_reg;
						s_next.fetch.addr = {req.addr[31:12], reg_offset};
						s_next.fetch.beats = req_beats;
						s_next.fsm = pbs_pkg::DR_FETCH;
					end
				end
			end
			pbs_pkg::DR_FETCH: begin
				if (fill.valid) begin
					s_next.fill_cnt = s_reg.fill_cnt + 3'h1;
					s_next.err = s_reg.err | fill.error;
					if (fill.last) begin
						s_next.disc = '0;
						s_next.fsm = s_reg.retry_mode ? pbs_pkg::DR_HELD : pbs_pkg::DR_PRIME;
					end
				end
				if (req_valid && s_reg.retry_mode) begin
					s_next.term.artry = 1'b1;
				end
			end
			pbs_pkg::DR_HELD: begin
				s_next.disc = s_reg.disc + 1'b1;
				if (req_valid && match) begin
					s_next.disc = '0;
					s_next.fsm = pbs_pkg::DR_PRIME;
				end else if (req_valid) begin
					s_next.term.artry = 1'b1;
				end else if (s_reg.disc == pbs_pkg::DISC_W'(DISCARD_LIMIT - 1)) begin
					s_next.disc = '0;
					s_next.fsm = pbs_pkg::DR_IDLE;
				end
			end
			pbs_pkg::DR_PRIME: begin
				s_next.cnt = pbs_pkg::COUNT_RESET;
				s_next.fsm = pbs_pkg::DR_SEND;
			end
			pbs_pkg::DR_SEND: begin
				s_next.cnt = s_reg.cnt + 3'h1;
				if ((s_reg.err && transfer_error_enable) || send_last) begin
					s_next.fsm = pbs_pkg::DR_IDLE;
				end
			end
			default: begin
				s_next.fsm = pbs_pkg::DR_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.fsm <= pbs_pkg::DR_IDLE;
			s_reg.lanes <= pbs_pkg::LANES_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	pbs_line_buffer #(
		.WIDTH(64),
		.DEPTH(pbs_pkg::LINE_WORDS),
		.AW(2)
	) u_line_buffer (
		.core_clk(core_clk),
		.rst(rst),
		.wr_en(wr_en),
		.wr_addr(s_reg.fill_cnt[1:0]),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// Beat strobes line up with the registered buffer output
	always_comb begin
		term = s_reg.term;
		data_valid = 1'b0;
		if (s_reg.fsm == pbs_pkg::DR_SEND) begin
			if (s_reg.err && transfer_error_enable) begin
				term.tea = 1'b1;
			end else begin
				data_valid = 1'b1;
				term.ta = s_reg.burst || send_last || !s_reg.ext;
				term.dval = s_reg.ext;
			end
		end
	end

	assign data_out = rd_data;
	assign lane_enable = s_reg.lanes;
	assign fetch = s_reg.fetch;
	assign req_ready = (s_reg.fsm == pbs_pkg::DR_IDLE) ||
		(s_reg.retry_mode && (s_reg.fsm == pbs_pkg::DR_FETCH || s_reg.fsm == pbs_pkg::DR_HELD));

endmodule

// >>> bench/pbs_props.sv
// Checker for the data phase at its ports.
// Assumes a bind onto pbs_data_phase, one clock domain.
`timescale 1ns/1ps
module pbs_props #(
	parameter int unsigned DISCARD_LIMIT = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control
	input wire logic transfer_error_enable,
	input wire logic address_retry_enable,
	input wire logic upper_word_select,
	// Request
	input wire logic req_valid,
	input wire pbs_pkg::pbs_req_type req,
	input wire logic req_ready,
	// Bus side
	input wire pbs_pkg::pbs_term_type term,
	input wire logic [63:0] data_out,
	input wire logic data_valid,
	input wire logic [7:0] lane_enable,
	// Memory side
	input wire pbs_pkg::pbs_fetch_type fetch,
	input wire pbs_pkg::pbs_fill_type fill
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic tk;
	logic reg8;
	assign tk = req_valid && req_ready;
	assign reg8 = tk && req.is_reg && req.tbst_n && req.tsiz == 4'h0;
	a_fetch_after_req: assert property (fetch.valid |-> $past(tk))
		else $error("fetch without request");
	a_retry_cause: assert property (term.artry |-> $past(tk && address_retry_enable))
		else $error("retry without cause");
	a_no_retry_off: assert property (tk && !address_retry_enable |=> !term.artry)
		else $error("retry while disabled");
	a_reg_wide_tea: assert property (reg8 && transfer_error_enable |=> term.tea && !fetch.valid)
		else $error("wide register read not errored");
	a_reg_ta_sub: assert property (tk && req.is_reg && req.tsiz[3]
		&& !transfer_error_enable |=> term.ta && !term.tea)
		else $error("error not ended by ta");
	a_hold_bus: assert property (tk && !address_retry_enable && !req.is_reg |=> !req_ready)
		else $error("bus not held");
	a_reg_offset: assert property (reg8 && !transfer_error_enable
		&& !address_retry_enable |=> fetch.valid && fetch.addr[11:0] ==
		(($past(req.addr[11:0]) & 12'hff8) + ($past(upper_word_select) ? 12'h004 : 12'h000)))
		else $error("register offset wrong");
	a_burst_fetch: assert property (tk && !req.tbst_n && !address_retry_enable
		|=> fetch.valid && fetch.beats == 3'h4 && fetch.addr[31:3] == $past(req.addr[31:3]))
		else $error("burst fetch wrong");
	a_ext_dval_run: assert property (term.dval && !term.ta |=> data_valid && term.dval)
		else $error("extended beats broken");
	a_wide_lanes: assert property (term.dval |-> lane_enable == 8'hff)
		else $error("extended lanes wrong");
	cover property (term.artry);
	cover property (term.dval && term.ta);
	cover property (term.tea);
endmodule
bind pbs_data_phase pbs_props #(.DISCARD_LIMIT(DISCARD_LIMIT)) pbs_props_i (
	.core_clk(core_clk), .rst(rst), .transfer_error_enable(transfer_error_enable),
	.address_retry_enable(address_retry_enable), .upper_word_select(upper_word_select),
	.req_valid(req_valid), .req(req), .req_ready(req_ready), .term(term),
	.data_out(data_out), .data_valid(data_valid), .lane_enable(lane_enable),
	.fetch(fetch), .fill(fill));

// >>> bench/pbs_mem_model.sv
// Memory and register side model: answers each fetch after a delay.
// Assumes fetch pulses one cycle; beats wrap inside a 32-byte line.
`timescale 1ns/1ps
module pbs_mem_model (
	// Clock
	input wire logic core_clk,
	// Fetch in, beats out
	input wire pbs_pkg::pbs_fetch_type fetch,
	input wire logic [3:0] dly,
	output pbs_pkg::pbs_fill_type fill
);
	logic [2:0] left = 3'h0;
	logic [1:0] k;
	logic [3:0] t;
	logic [31:0] a;
	logic [31:0] w;
	logic r;
	initial fill = '0;
	assign w = {a[31:5], a[4:3] + k, 3'h0};
	always @(posedge core_clk) begin
		fill.valid <= 1'b0;
		fill.last <= 1'b0;
		fill.error <= 1'b0;
		fill.data <= ~fill.data;
		if (fetch.valid) begin
			{left, k, t, a, r} <= {fetch.beats, 2'h0, dly, fetch.addr, fetch.is_reg};
		end else if (left != 3'h0 && t != 4'h0) begin
			t <= t - 4'h1;
		end else if (left != 3'h0) begin
			fill.valid <= 1'b1;
			fill.last <= left == 3'h1;
			fill.error <= r && a[11:0] == 12'hffc;
			left <= left - 3'h1;
			k <= k + 2'h1;
			fill.data <= r ? {32'h5a5a5a5a, 20'h0, a[11:0]} : {~w, w};
		end
	end
endmodule

// >>> bench/tb_pbs_data_phase.sv
// Self-checking bench for the data phase with random and corner reads.
// Assumes the memory model answers fetches; control bits are driven here.
`timescale 1ns/1ps
module tb_pbs_data_phase;
	logic core_clk = 0, rst = 1, tee = 0, are = 0, uws = 0, req_valid = 0;
	logic req_ready, data_valid;
	logic [63:0] data_out;
	logic [7:0] lane_enable;
	logic [3:0] dly = 4'h4;
	logic [31:0] x, seed = 32'd92828;
	pbs_pkg::pbs_req_type req = '0;
	pbs_pkg::pbs_term_type term, t;
	pbs_pkg::pbs_fetch_type fetch;
	pbs_pkg::pbs_fill_type fill;
	int fail_count = 0, check_count = 0, n, a, ar, i;
	pbs_data_phase #(.DISCARD_LIMIT(16)) pbs_data_phase_i (.core_clk(core_clk), .rst(rst),
		.transfer_error_enable(tee), .address_retry_enable(are), .upper_word_select(uws),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .term(term),
		.data_out(data_out), .data_valid(data_valid), .lane_enable(lane_enable),
		.fetch(fetch), .fill(fill));
	pbs_mem_model pbs_mem_model_i (.core_clk(core_clk), .fetch(fetch), .dly(dly), .fill(fill));
	initial forever #20 core_clk = ~core_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] lanes(input logic [2:0] s, input int a);
		return (8'hff >> (4'h8 - (s == 3'h0 ? 4'h8 : {1'b0, s}))) << a;
	endfunction
	task test_done();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task go(input pbs_pkg::pbs_req_type q);
		int j;
		for (j = 0; j < 200; j++) begin
			@(negedge core_clk);
			if (req_ready === 1'b1) break;
		end
		if (j == 200) begin
			fail_count++;
			$display("mismatch ready expected high seen low");
			test_done();
		end
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= q;
		dly <= 4'(4 + rnd() % 8);
		@(posedge core_clk);
		req_valid <= 1'b0;
	endtask
	task wt(input bit f);
		int j;
		for (j = 0; j < 200; j++) begin
			@(negedge core_clk);
			if (f ? (fill.valid && fill.last) === 1'b1 : (term != 4'h0 || data_valid)) break;
		end
		if (j == 200) begin
			fail_count++;
			$display("mismatch wait expected event seen none");
			test_done();
		end
		t = term;
	endtask
	task rd(input logic r, input logic b, input logic [3:0] s, input logic [31:0] a);
		int nb;
		logic [31:0] w;
		logic [63:0] e;
		nb = !b ? 4 : s[3] ? s[2:0] + 1 : 1;
		go({r, b, s, a});
		if (are) begin
			wt(0);
			chk("artry", t.artry, 1);
			go({r, b, s, a});
			wt(0);
			chk("early", t.artry, 1);
			wt(1);
			go({r, b, s, a});
		end
		for (int k = 0; k < nb; k++) begin
			wt(0);
			w = {a[31:5], a[4:3] + 2'(k), 3'h0};
			e = r ? {2{20'h0, (a[11:0] & 12'hff8) + (uws ? 12'h4 : 12'h0)}} : {~w, w};
			chk("data", data_out, e);
			chk("ta", t.ta, !b || k == nb - 1);
			chk("dval", t.dval, s[3] & b);
			chk("lanes", lane_enable, (nb > 1 || r) ? 8'hff : lanes(s[2:0], a[2:0]));
		end
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		for (ar = 0; ar < 2; ar++) begin
			@(posedge core_clk);
			are <= ar[0];
			for (n = 1; n <= 8; n++) for (a = 0; a < 8; a++)
				if (n <= 4 ? (a % 4) + n <= 4 : (a == 0 || a + n == 8)) begin
					x = rnd();
					rd(0, 1, {1'b0, 3'(n)}, {x[31:3], 3'(a)});
				end
			for (i = 0; i < 12; i++) begin
				x = rnd();
				@(posedge core_clk);
				uws <= x[2];
				if (x[0]) rd(0, 0, 4'h2, x);
				else rd(0, 1, x[1] ? 4'ha : 4'h9, x);
				rd(1, 1, 4'h0, x);
			end
			$display("test reads retry %0d done", ar);
		end
		@(posedge core_clk);
		are <= 1'b0;
		tee <= 1'b1;
		x = rnd();
		go({1'b1, 1'b1, 4'h0, x});
		wt(0);
		chk("tea", t.tea, 1);
		go({1'b1, 1'b1, 4'h4, 32'h00000ffc});
		wt(0);
		chk("fill_tea", {t.ta, t.tea, data_valid}, 3'b010);
		@(posedge core_clk);
		tee <= 1'b0;
		go({1'b1, 1'b1, 4'h9, x});
		wt(0);
		chk("ta_for_tea", {t.ta, t.tea}, 2'b10);
		$display("test errors done");
		@(posedge core_clk);
		are <= 1'b1;
		go({1'b0, 1'b1, 4'h4, x});
		wt(0);
		chk("artry", t.artry, 1);
		wt(1);
		repeat (20) begin
			@(negedge core_clk);
			chk("silent", {term, data_valid}, 5'h0);
		end
		go({1'b0, 1'b1, 4'h4, x});
		wt(0);
		chk("refetch", t.artry, 1);
		wt(1);
		go({1'b0, 1'b1, 4'h4, x});
		wt(0);
		chk("collect", t.ta, 1);
		$display("test discard done");
		test_done();
	end
endmodule
